// file: logic/pss_pkg.sv
package pss_pkg;

    // Array shape
    localparam int ADDR_W  = 17;
    localparam int DATA_W  = 36;
    localparam int LANES   = 4;
    localparam int BURST_W = 2;

    // Pin levels
    localparam logic QUAL_RUN     = 1'b0;
    localparam logic QUAL_HOLD    = 1'b1;
    localparam logic ADV_LOAD     = 1'b0;
    localparam logic ADV_BURST    = 1'b1;
    localparam logic RW_READ      = 1'b1;
    localparam logic RW_WRITE     = 1'b0;
    localparam logic SEL_ON_N     = 1'b0;
    localparam logic SEL_OFF_N    = 1'b1;
    localparam logic SEL_ON       = 1'b1;
    localparam logic SEL_OFF      = 1'b0;
    localparam logic OE_ACTIVE_N  = 1'b0;

    // Reset values
    localparam logic OUT_FLOAT    = 1'b0;
    localparam logic FLAG_CLEAR   = 1'b0;

    // Burst address step
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    typedef enum logic [1:0]
    {
        PSS_OP_IDLE  = 2'b00,
        PSS_OP_READ  = 2'b01,
        PSS_OP_WRITE = 2'b10
    } pss_op_t;

endpackage

// file: logic/pss_bus_if.sv
`timescale 1ns/1ps

interface pss_bus_if
#(
    parameter int ADDR_W = pss_pkg::ADDR_W,
    parameter int DATA_W = pss_pkg::DATA_W,
    parameter int LANES  = pss_pkg::LANES
);
    logic [ADDR_W-1:0] addr;
    logic              read_write;
    logic              advance_or_load;
    logic              select_low_a_n;
    logic              select_high_or_low_b_n;
    logic              select_high_or_low_b;
    logic [LANES-1:0]  byte_write_strobes_n;
    logic              edge_qualify_n;
    logic              output_enable_n;
    logic [DATA_W-1:0] ctl_dq_out;
    logic              ctl_dq_oe;
    logic [DATA_W-1:0] dev_dq_out;
    logic              dev_dq_oe;
    logic [DATA_W-1:0] dq;
    logic              bus_clash;

    // Resolved data wire; an undriven bus reads as zero
    assign dq        = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);
    assign bus_clash = dev_dq_oe && ctl_dq_oe;

    modport ctl
    (
        output addr, read_write, advance_or_load, select_low_a_n,
        output select_high_or_low_b_n, select_high_or_low_b, byte_write_strobes_n,
        output edge_qualify_n, output_enable_n, ctl_dq_out, ctl_dq_oe,
        input  dq
    );

    modport dev
    (
        input  addr, read_write, advance_or_load, select_low_a_n,
        input  select_high_or_low_b_n, select_high_or_low_b, byte_write_strobes_n,
        input  edge_qualify_n, output_enable_n, dq,
        output dev_dq_out, dev_dq_oe
    );
endinterface

// file: logic/pss_mem.sv
`timescale 1ns/1ps

module pss_mem
#(
    parameter int ADDR_W = pss_pkg::ADDR_W,
    parameter int DATA_W = pss_pkg::DATA_W,
    parameter int LANES  = pss_pkg::LANES
)
(
    // Clock
    input  wire logic              clock,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [LANES-1:0]  wr_lanes_n,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);
    localparam int LANE_W = DATA_W / LANES;

    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // Read is combinational; the caller registers it
    assign rd_data = cells[rd_addr];

    // One process owns the array so that no word has two drivers
    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (!wr_lanes_n[i])
                begin
                    cells[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end
endmodule

// file: logic/pss_sram_dev.sv
// Functional notes
// (R01) Inputs sampled only on qualified edges
// (R02) Unqualified edge holds state and output word
// (R03) Data moves two qualified edges after load
// (R04) Loads every edge give back-to-back words
// (R05) New address accepted while old data leaves
// (R06) Deselect starts nothing, stops burst, drains pipe
// (R07) Pending write data captured on deselect edge
// (R08) Write load and earlier write data coincide
// (R09) Outputs float from first edge onward
// (R10) Float two edges after deselect or write
// (R11) Selected only with all three selects active
`timescale 1ns/1ps

module pss_sram_dev
#(
    parameter int ADDR_W  = pss_pkg::ADDR_W,
    parameter int DATA_W  = pss_pkg::DATA_W,
    parameter int LANES   = pss_pkg::LANES,
    parameter int BURST_W = pss_pkg::BURST_W
)
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Memory bus
    pss_bus_if.dev    bus,
    // Status
    output logic      read_driving,
    output logic      burst_running
);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle decode

    logic                qualified;
    logic                selected;
    logic                loading;
    pss_pkg::pss_op_t    new_op;
    logic [ADDR_W-1:0]   new_addr;

    logic                burst_reg;
    pss_pkg::pss_op_t    burst_op_reg;
    logic [ADDR_W-1:0]   burst_addr_reg;

    assign qualified = (bus.edge_qualify_n == pss_pkg::QUAL_RUN); // R01
    assign loading   = (bus.advance_or_load == pss_pkg::ADV_LOAD);

    assign selected = (bus.select_low_a_n == pss_pkg::SEL_ON_N)
                   && (bus.select_high_or_low_b_n == pss_pkg::SEL_ON_N)
                   && (bus.select_high_or_low_b == pss_pkg::SEL_ON); // R11

    always_comb
    begin
        new_op   = pss_pkg::PSS_OP_IDLE;
        new_addr = burst_addr_reg;
        if (loading)
        begin
            if (selected)
            begin
                new_op   = (bus.read_write == pss_pkg::RW_READ) ? pss_pkg::PSS_OP_READ
                                                                 : pss_pkg::PSS_OP_WRITE;
                new_addr = bus.addr; // R05 R08
            end
        end
        else if (burst_reg)
        begin
            // Linear wrap inside the aligned group of four
            new_op   = burst_op_reg;
            new_addr = {burst_addr_reg[ADDR_W-1:BURST_W],
                        burst_addr_reg[BURST_W-1:0] + pss_pkg::BURST_STEP};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst tracking

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            burst_reg    <= pss_pkg::FLAG_CLEAR;
            burst_op_reg <= pss_pkg::PSS_OP_IDLE;
        end
        else if (qualified) // R02
        begin
            if (loading)
            begin
                burst_reg    <= selected; // R06
                burst_op_reg <= new_op;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (qualified && (new_op != pss_pkg::PSS_OP_IDLE))
        begin
            burst_addr_reg <= new_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage operation pipe

    pss_pkg::pss_op_t    s1_op_reg;
    pss_pkg::pss_op_t    s2_op_reg;
    logic [ADDR_W-1:0]   s1_addr_reg;
    logic [ADDR_W-1:0]   s2_addr_reg;
    logic [LANES-1:0]    s1_lanes_n_reg;
    logic [LANES-1:0]    s2_lanes_n_reg;

    // Stages only move on qualified edges, so suspended edges are not counted
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            s1_op_reg <= pss_pkg::PSS_OP_IDLE;
            s2_op_reg <= pss_pkg::PSS_OP_IDLE;
        end
        else if (qualified) // R02 R03
        begin
            s1_op_reg <= new_op; // R06
            s2_op_reg <= s1_op_reg; // R04
        end
    end

    always_ff @(posedge clock)
    begin
        if (qualified) // R02
        begin
            s1_addr_reg    <= new_addr;
            s1_lanes_n_reg <= bus.byte_write_strobes_n; // R01
            s2_addr_reg    <= s1_addr_reg;
            s2_lanes_n_reg <= s1_lanes_n_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array

    logic                mem_wr_en;
    logic [DATA_W-1:0]   mem_rd_data;

    // Write data is taken whatever the current cycle's own command is
    assign mem_wr_en = qualified && (s2_op_reg == pss_pkg::PSS_OP_WRITE); // R03 R07 R08

    pss_mem
    #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .LANES  (LANES)
    )
    u_mem
    (
        .clock      (clock),
        .wr_en      (mem_wr_en),
        .wr_addr    (s2_addr_reg),
        .wr_data    (bus.dq),
        .wr_lanes_n (s2_lanes_n_reg),
        .rd_addr    (s1_addr_reg),
        .rd_data    (mem_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output register

    localparam int LANE_W = DATA_W / LANES;

    logic                out_en_reg;
    logic [DATA_W-1:0]   out_data_reg;
    logic [DATA_W-1:0]   rd_word;

    // A write leaving stage two lands on the edge that loads the read word,
    // so its lanes are forwarded to keep read-after-write order
    always_comb
    begin
        rd_word = mem_rd_data;
        if (mem_wr_en && (s2_addr_reg == s1_addr_reg))
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (!s2_lanes_n_reg[i])
                begin
                    rd_word[i*LANE_W +: LANE_W] = bus.dq[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Read word is launched one stage early so it stands on the bus at the
    // same edge a write word would; reads and writes never overlap on dq
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            out_en_reg <= pss_pkg::OUT_FLOAT; // R09
        end
        else if (qualified)
        begin
            // Deselect, idle or write in the stage before all float the bus
            out_en_reg <= (s1_op_reg == pss_pkg::PSS_OP_READ); // R10
        end
    end

    always_ff @(posedge clock)
    begin
        if (qualified && (s1_op_reg == pss_pkg::PSS_OP_READ)) // R03 R06
        begin
            out_data_reg <= rd_word; // R04
        end
    end

    // Output enable acts without the clock, like the pin it models
    assign bus.dev_dq_oe  = out_en_reg && (bus.output_enable_n == pss_pkg::OE_ACTIVE_N); // R02
    assign bus.dev_dq_out = out_data_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Status

    assign read_driving  = bus.dev_dq_oe;
    assign burst_running = burst_reg;

endmodule

// file: logic/pss_sram_ctl.sv
`timescale 1ns/1ps

module pss_sram_ctl
#(
    parameter int ADDR_W = pss_pkg::ADDR_W,
    parameter int DATA_W = pss_pkg::DATA_W,
    parameter int LANES  = pss_pkg::LANES
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Memory bus
    pss_bus_if.ctl                 bus,
    // Request
    input  wire logic              suspend,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_burst,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [LANES-1:0]  req_lanes,
    output logic                   req_ready,
    // Response
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin registers

    logic                qual_n_reg;
    logic                adv_reg;
    logic                rw_reg;
    logic                sel_reg;
    logic [ADDR_W-1:0]   addr_reg;
    logic [LANES-1:0]    lanes_n_reg;
    logic [DATA_W-1:0]   wdata_reg;

    assign req_ready = !suspend;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            qual_n_reg <= pss_pkg::QUAL_RUN;
            adv_reg   <= pss_pkg::ADV_LOAD;
            sel_reg   <= pss_pkg::FLAG_CLEAR;
            rw_reg    <= pss_pkg::RW_READ;
        end
        else
        begin
            qual_n_reg <= suspend ? pss_pkg::QUAL_HOLD : pss_pkg::QUAL_RUN; // R01
            if (!suspend)
            begin
                adv_reg <= (req_valid && req_burst) ? pss_pkg::ADV_BURST : pss_pkg::ADV_LOAD;
                sel_reg <= req_valid && !req_burst;
                rw_reg  <= req_write ? pss_pkg::RW_WRITE : pss_pkg::RW_READ;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!suspend) // R01
        begin
            addr_reg    <= req_addr;
            lanes_n_reg <= ~req_lanes;
            wdata_reg   <= req_wdata;
        end
    end

    // All three selects move together
    assign bus.select_low_a_n         = sel_reg ? pss_pkg::SEL_ON_N : pss_pkg::SEL_OFF_N; // R11
    assign bus.select_high_or_low_b_n = sel_reg ? pss_pkg::SEL_ON_N : pss_pkg::SEL_OFF_N; // R11
    assign bus.select_high_or_low_b   = sel_reg ? pss_pkg::SEL_ON : pss_pkg::SEL_OFF; // R11
    assign bus.edge_qualify_n         = qual_n_reg;
    assign bus.advance_or_load        = adv_reg;
    assign bus.read_write             = rw_reg;
    assign bus.addr                   = addr_reg;
    assign bus.byte_write_strobes_n   = lanes_n_reg;
    assign bus.output_enable_n        = pss_pkg::OE_ACTIVE_N;

    ////////////////////////////////////////////////////////////////////////////
    // Mirror of the device pipe

    logic                taken;
    logic                burst_reg;
    pss_pkg::pss_op_t    burst_op_reg;
    pss_pkg::pss_op_t    issued_op;
    pss_pkg::pss_op_t    c1_op_reg;
    pss_pkg::pss_op_t    c2_op_reg;
    logic [DATA_W-1:0]   c1_data_reg;
    logic [DATA_W-1:0]   c2_data_reg;

    assign taken = (qual_n_reg == pss_pkg::QUAL_RUN);

    always_comb
    begin
        issued_op = pss_pkg::PSS_OP_IDLE;
        if (adv_reg == pss_pkg::ADV_LOAD)
        begin
            if (sel_reg)
            begin
                issued_op = (rw_reg == pss_pkg::RW_WRITE) ? pss_pkg::PSS_OP_WRITE
                                                           : pss_pkg::PSS_OP_READ;
            end
        end
        else if (burst_reg)
        begin
            issued_op = burst_op_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            burst_reg    <= pss_pkg::FLAG_CLEAR;
            burst_op_reg <= pss_pkg::PSS_OP_IDLE;
            c1_op_reg    <= pss_pkg::PSS_OP_IDLE;
            c2_op_reg    <= pss_pkg::PSS_OP_IDLE;
        end
        else if (taken) // R03
        begin
            if (adv_reg == pss_pkg::ADV_LOAD)
            begin
                burst_reg    <= sel_reg;
                burst_op_reg <= issued_op;
            end
            c1_op_reg <= issued_op;
            c2_op_reg <= c1_op_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (taken)
        begin
            c1_data_reg <= wdata_reg;
            c2_data_reg <= c1_data_reg;
        end
    end

    // Held through suspended edges until the next qualified edge takes it
    assign bus.ctl_dq_oe  = (c2_op_reg == pss_pkg::PSS_OP_WRITE); // R03 R07 R08
    assign bus.ctl_dq_out = c2_data_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read return

    // Read word is taken at the same qualified edge a write word would be
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rsp_valid <= pss_pkg::FLAG_CLEAR;
        end
        else
        begin
            rsp_valid <= taken && (c2_op_reg == pss_pkg::PSS_OP_READ); // R03
        end
    end

    always_ff @(posedge clock)
    begin
        if (taken && (c2_op_reg == pss_pkg::PSS_OP_READ))
        begin
            rsp_data <= bus.dq;
        end
    end

endmodule

// file: tb/pss_sram_chk.sv
`timescale 1ns/1ps

module pss_sram_chk
#(
    parameter int ADDR_W = pss_pkg::ADDR_W,
    parameter int DATA_W = pss_pkg::DATA_W
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Controller pins
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              read_write,
    input  wire logic              advance_or_load,
    input  wire logic              select_low_a_n,
    input  wire logic              select_high_or_low_b_n,
    input  wire logic              select_high_or_low_b,
    input  wire logic              edge_qualify_n,
    input  wire logic              ctl_dq_oe,
    // Device drive
    input  wire logic [DATA_W-1:0] dev_dq_out,
    input  wire logic              dev_dq_oe,
    input  wire logic              bus_clash
);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    logic q;
    logic sel;
    logic ld_rd;
    logic ld_wr;
    logic desel;
    logic rd1_reg;
    logic wr1_reg;
    logic wr2_reg;

    assign q     = edge_qualify_n == pss_pkg::QUAL_RUN;
    assign sel   = select_low_a_n == pss_pkg::SEL_ON_N
                && select_high_or_low_b_n == pss_pkg::SEL_ON_N
                && select_high_or_low_b == pss_pkg::SEL_ON;
    assign ld_rd = q && sel && advance_or_load == pss_pkg::ADV_LOAD
                && read_write == pss_pkg::RW_READ;
    assign ld_wr = q && sel && advance_or_load == pss_pkg::ADV_LOAD
                && read_write == pss_pkg::RW_WRITE;
    assign desel = q && !sel && advance_or_load == pss_pkg::ADV_LOAD;

    // Stages advance only on qualified edges, so suspends stretch them
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            rd1_reg <= 1'b0;
        end
        else if (q)
        begin
            rd1_reg <= ld_rd;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wr1_reg <= 1'b0;
            wr2_reg <= 1'b0;
        end
        else if (q)
        begin
            wr1_reg <= ld_wr;
            wr2_reg <= wr1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_PINS_HELD: assert property (!q |-> $stable(addr) && $stable(read_write)
        && $stable(select_low_a_n)) else $error("pins moved on an ignored edge");
    AST_HOLD_WORD: assert property (!q && dev_dq_oe |=> dev_dq_oe
        && $stable(dev_dq_out)) else $error("read word changed on an ignored edge");
    AST_READ_OUT: assert property (q && rd1_reg |=> dev_dq_oe)
        else $error("read data not driven by the second qualified edge after load");
    AST_FLOAT: assert property (q && !rd1_reg |=> !dev_dq_oe)
        else $error("device drives after deselect or write");
    AST_POWER_FLOAT: assert property (!$past(rst_b) |-> !dev_dq_oe)
        else $error("device drives right after reset");
    AST_WR_DATA: assert property (q && wr2_reg |-> ctl_dq_oe && !dev_dq_oe)
        else $error("write data missing at its capture edge");
    AST_BACK_TO_BACK: assert property (ld_rd ##1 ld_rd ##1 q
        |-> dev_dq_oe ##1 dev_dq_oe) else $error("gap between back to back reads");
    AST_NO_CLASH: assert property (!bus_clash)
        else $error("both ends drive the data bus");

    COV_SUSP_READ: cover property (ld_rd ##1 !q ##1 !q);
    COV_WR_DESEL: cover property (ld_wr ##1 desel ##1 desel);
    COV_TURN: cover property (ld_rd ##1 ld_wr ##1 ld_rd);

endmodule

// file: tb/pipelined_sram_suspend_deselect_tb_top.sv
`timescale 1ns/1ps

module pipelined_sram_suspend_deselect_tb_top;

    localparam int AW = pss_pkg::ADDR_W;
    localparam int DW = pss_pkg::DATA_W;
    localparam int NL = pss_pkg::LANES;
    localparam int LW = DW / NL;

    logic          clock     = 1'b0;
    logic          rst_b     = 1'b0;
    logic          suspend   = 1'b0;
    logic          req_valid = 1'b0;
    logic          req_write = 1'b0;
    logic [AW-1:0] req_addr  = '0;
    logic [DW-1:0] req_wdata = '0;
    logic [NL-1:0] req_lanes = '0;
    logic          req_ready;
    logic          rsp_valid;
    logic [DW-1:0] rsp_data;
    logic [31:0]   lfsr      = 32'h20;
    int            failures  = 0;
    int            n_checks  = 0;
    logic [DW-1:0] mem_model [logic [AW-1:0]];
    logic [DW-1:0] exp_q [$];

    always #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    pss_bus_if bus_if ();

    pss_sram_ctl pss_sram_ctl_inst
    (
        .clock(clock), .rst_b(rst_b), .bus(bus_if.ctl), .suspend(suspend),
        .req_valid(req_valid), .req_write(req_write), .req_burst(1'b0),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data)
    );

    pss_sram_dev pss_sram_dev_inst
    (
        .clock(clock), .rst_b(rst_b), .bus(bus_if.dev),
        .read_driving(), .burst_running()
    );

    pss_sram_chk pss_sram_chk_inst
    (
        .clock(clock), .rst_b(rst_b), .addr(bus_if.addr),
        .read_write(bus_if.read_write), .advance_or_load(bus_if.advance_or_load),
        .select_low_a_n(bus_if.select_low_a_n),
        .select_high_or_low_b_n(bus_if.select_high_or_low_b_n),
        .select_high_or_low_b(bus_if.select_high_or_low_b),
        .edge_qualify_n(bus_if.edge_qualify_n), .ctl_dq_oe(bus_if.ctl_dq_oe),
        .dev_dq_out(bus_if.dev_dq_out), .dev_dq_oe(bus_if.dev_dq_oe),
        .bus_clash(bus_if.bus_clash)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [DW-1:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return {lfsr[3:0], lfsr};
    endfunction

    // Eight words at each end of the address space
    function automatic logic [AW-1:0] addr_of(input logic [3:0] k);
        return {{(AW-3){k[3]}}, k[2:0]};
    endfunction

    task automatic cmp_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_count(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic issue(input logic v, input logic w, input logic [AW-1:0] a,
                         input logic [DW-1:0] d, input logic [NL-1:0] ln, input logic s);
        @(posedge clock);
        suspend   <= s;
        req_valid <= v;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        req_lanes <= ln;
    endtask

    task automatic drain();
        issue(1'b0, 1'b0, '0, '0, '0, 1'b0);
        for (int k = 0; k < 40 && exp_q.size() > 0; k++)
            @(posedge clock);
        // Let trailing writes reach the array before anything resets the pipe
        repeat (4) @(posedge clock);
        cmp_count(exp_q.size(), 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reference model: order of acceptance is order of effect on the array
    always @(posedge clock)
    begin
        if (rst_b && !suspend && req_valid)
        begin
            if (req_write)
            begin
                for (int i = 0; i < NL; i++)
                    if (req_lanes[i])
                        mem_model[req_addr][i*LW +: LW] = req_wdata[i*LW +: LW];
            end
            else
                exp_q.push_back(mem_model[req_addr]);
        end
        if (rst_b && rsp_valid === 1'b1)
        begin
            if (exp_q.size() > 0)
                cmp_data(rsp_data, exp_q.pop_front());
            else
                cmp_count(1, 0);
        end
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        failures++;
        end_sim();
    end

    initial
    begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        for (int k = 0; k < 16; k++)
            issue(1'b1, 1'b1, addr_of(k[3:0]), rnd(), '1, 1'b0);
        for (int k = 0; k < 16; k++)
            issue(1'b1, 1'b0, addr_of(k[3:0]), '0, '1, 1'b0);
        // Reads, writes, deselects and suspends mixed at random
        for (int k = 0; k < 600; k++)
            issue(lfsr[0] | lfsr[1], lfsr[2], addr_of(lfsr[6:3]), rnd(),
                  lfsr[11:8], lfsr[12] & lfsr[13]);
        drain();
        // Second reset mid-run; the array keeps its contents
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        for (int k = 0; k < 16; k++)
            issue(1'b1, 1'b0, addr_of(k[3:0]), '0, '1, k % 4 == 3);
        drain();
        end_sim();
    end

endmodule
